//--- logic/mfr_read_front.sv
// How it works
// - quad output read returns four data bits per clock on all lines.
// - opcode and address sampled on sck rise, data driven on fall.
// - address advances per byte and wraps from the top to zero.
// - chip select high ends the read and stops the drivers.
// - reads are ignored while a program, erase or write runs.
// - quad opcodes accepted only with config bit one set; continuous quad frames are served without checking it.
// - dual io read takes address two bits per clock.
// - dual io: serial opcode, address and mode two-wide, data two-wide.
// - only the upper mode nibble is decoded, lower ignored.
// - dual mode nibble A skips the opcode in the next frame.
// - any other dual mode value needs a full opcode next frame.
// - a short frame without a valid sequence drops dual continuous.
// - quad io read takes address four bits per clock.
// - quad io: address and mode four-wide, four dummies, data.
// - quad mode nibble A skips the opcode in the next frame.
// - any other quad mode value needs a full opcode next frame.
// - a short frame without a valid sequence drops quad continuous.
`timescale 1ns/10ps
`include "mfr_consts.svh"
module mfr_read_front
  import mfr_pkg::*;
#(
  parameter int       ARRAY_AW   = `MFR_ARRAY_AW_DFLT,
  parameter bit [7:0] QOR_OPCODE = `MFR_OPC_QOR_DFLT
) (
  // system clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // system side
  input  wire logic       busy,
  input  wire logic [7:0] config_reg,
  input  mfr_wr_s         arr_wr,
  output mfr_stat_s       status,
  // link side
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] data_line_in,
  output logic      [3:0] data_line_out,
  output logic      [3:0] data_line_oe
);

  // ========================================================================
  // parameter check
  generate
    if (ARRAY_AW < 1 || ARRAY_AW > `MFR_ADDR_W) begin : g_bad_aw
      $error("mfr_read_front: ARRAY_AW out of range");
    end
    if (QOR_OPCODE == `MFR_OPC_DUAL_IO_FAST_READ ||
        QOR_OPCODE == `MFR_OPC_QUAD_IO_FAST_READ) begin : g_bad_opc
      $error("mfr_read_front: QOR_OPCODE clashes with an io read code");
    end
  endgenerate

  // ========================================================================
  // system clock side
  logic        busy_q;
  logic        busy_d;
  logic        qe_q;
  logic        qe_d;
  logic [1:0]  to_link;
  logic [1:0]  at_link;
  logic        busy_s;
  logic        qe_s;
  logic [1:0]  xip_lnk;
  logic [1:0]  xip_sys;

  always_comb begin
    busy_d = busy;
    qe_d   = config_reg[`MFR_CFG_QE_BIT];
  end

  // registered so the crossing sees a clean level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      qe_q   <= 1'b0;
    end else begin
      busy_q <= busy_d;
      qe_q   <= qe_d;
    end
  end

  assign to_link = {busy_q, qe_q};

  mfr_sync #(.W(2)) u_sync_in (
    .clk   (sck),
    .rst_n (rst_n),
    .din   (to_link),
    .dout  (at_link)
  );

  assign busy_s = at_link[1];
  assign qe_s   = at_link[0];

  mfr_sync #(.W(2)) u_sync_out (
    .clk   (mclk),
    .rst_n (rst_n),
    .din   (xip_lnk),
    .dout  (xip_sys)
  );

  // one driver for the whole struct; packed order is {dual, quad}
  assign status = mfr_stat_s'(xip_sys);

  // ========================================================================
  // link frame state, cleared while chip select is high
  logic        frame_rst_n;
  mfr_phase_e  ph_q;
  mfr_phase_e  ph_d;
  mfr_cmd_e    cmd_q;
  mfr_cmd_e    cmd_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [23:0] addr_q;
  logic [23:0] addr_d;
  // continuous-read flags survive frames
  logic        xd_q;
  logic        xd_d;
  logic        xq_q;
  logic        xq_d;
  logic        pend_q;
  logic        pend_d;
  // working terms
  mfr_phase_e  cur_ph;
  mfr_cmd_e    cur_cmd;
  logic        cont_d;
  logic        cont_q4;
  logic [1:0]  lw;
  logic [4:0]  last;
  logic [7:0]  opc;

  assign frame_rst_n = rst_n & ~cs_n;
  assign xip_lnk     = {xd_q, xq_q};
  assign opc         = {sh_q[6:0], data_line_in[0]};

  always_comb begin
    // a frame opens in address phase when continuous read is armed and
    // the previous continuous frame completed its mode byte
    cont_d  = xd_q & ~pend_q;
    cont_q4 = xq_q & ~pend_q;
    cur_ph  = ph_q;
    cur_cmd = cmd_q;
    if (ph_q == PH_START) begin
      cur_ph  = (cont_d | cont_q4) ? PH_ADDR : PH_OPC;
      cur_cmd = cont_d ? CMD_DUAL_IO_FAST_READ : (cont_q4 ? CMD_QUAD_IO_FAST_READ : CMD_NONE);
    end
    // lines per clock in the current phase
    lw = `MFR_LW_1;
    if (cur_ph == PH_ADDR || cur_ph == PH_MODE) begin
      if (cur_cmd == CMD_DUAL_IO_FAST_READ) lw = `MFR_LW_2;
      if (cur_cmd == CMD_QUAD_IO_FAST_READ) lw = `MFR_LW_4;
    end
    // shift the lines in, msb first, on the rising edge
    case (lw)
      `MFR_LW_4: sh_d = {sh_q[19:0], data_line_in[3:0]};
      `MFR_LW_2: sh_d = {sh_q[21:0], data_line_in[1:0]};
      default:   sh_d = {sh_q[22:0], data_line_in[0]};
    endcase
    // clocks in a phase less one; in the data phase, clocks per byte less one
    case (cur_ph)
      PH_ADDR:  last = (`MFR_ADDR_BITS >> lw) - 5'h01;
      PH_MODE:  last = (`MFR_BYTE_BITS >> lw) - 5'h01;
      PH_DUMMY: last = ((cur_cmd == CMD_QOR) ? `MFR_QOR_DUMMY
                                             : `MFR_QUAD_IO_FAST_READ_DUMMY) - 5'h01;
      PH_DATA:  last = (cur_cmd == CMD_DUAL_IO_FAST_READ) ? `MFR_DUAL_BYTE_LAST
                                             : `MFR_QUAD_BYTE_LAST;
      default:  last = `MFR_OPC_LAST;
    endcase
  end

  always_comb begin
    ph_d   = cur_ph;
    cmd_d  = cur_cmd;
    cnt_d  = cnt_q + 5'h01;
    addr_d = addr_q;
    xd_d   = xd_q;
    xq_d   = xq_q;
    pend_d = pend_q;
    if (ph_q == PH_START) begin
      // a continuous frame cut short before its mode byte drops the mode
      if (pend_q) begin
        xd_d = 1'b0;
        xq_d = 1'b0;
      end
      pend_d = cont_d | cont_q4;
    end
    case (cur_ph)
      PH_OPC: begin
        if (cnt_q == last) begin
          cnt_d = 5'h00;
          ph_d  = PH_ADDR;
          if (opc == `MFR_OPC_DUAL_IO_FAST_READ) begin
            cmd_d = CMD_DUAL_IO_FAST_READ;
          end else if (opc == `MFR_OPC_QUAD_IO_FAST_READ && qe_s) begin
            cmd_d = CMD_QUAD_IO_FAST_READ;
          end else if (opc == QOR_OPCODE && qe_s) begin
            cmd_d = CMD_QOR;
          end else begin
            ph_d = PH_IGNORE;
          end
        end
      end
      PH_ADDR: begin
        if (cnt_q == last) begin
          cnt_d  = 5'h00;
          addr_d = sh_d;
          if (busy_s) begin
            ph_d = PH_IGNORE;
          end else if (cur_cmd == CMD_QOR) begin
            ph_d = PH_DUMMY;
          end else begin
            ph_d = PH_MODE;
          end
        end
      end
      PH_MODE: begin
        if (cnt_q == last) begin
          cnt_d  = 5'h00;
          pend_d = 1'b0;
          // low nibble is a don't care
          if (cur_cmd == CMD_DUAL_IO_FAST_READ) begin
            xd_d = (sh_d[7:4] == `MFR_XIP_NIBBLE);
            xq_d = 1'b0;
            ph_d = PH_DATA;
          end else begin
            xq_d = (sh_d[7:4] == `MFR_XIP_NIBBLE);
            xd_d = 1'b0;
            ph_d = PH_DUMMY;
          end
        end
      end
      PH_DUMMY: begin
        if (cnt_q == last) begin
          cnt_d = 5'h00;
          ph_d  = PH_DATA;
        end
      end
      PH_DATA: begin
        if (cnt_q == last) begin
          cnt_d  = 5'h00;
          addr_d = addr_q + 24'h000001;
        end
      end
      PH_IGNORE: begin
        cnt_d = cnt_q;
      end
      default: begin
        ph_d = PH_IGNORE;
      end
    endcase
  end

  always_ff @(posedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ph_q   <= PH_START;
      cmd_q  <= CMD_NONE;
      cnt_q  <= 5'h00;
      sh_q   <= 24'h000000;
      addr_q <= 24'h000000;
    end else begin
      ph_q   <= ph_d;
      cmd_q  <= cmd_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      addr_q <= addr_d;
    end
  end

  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      xd_q   <= 1'b0;
      xq_q   <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      xd_q   <= xd_d;
      xq_q   <= xq_d;
      pend_q <= pend_d;
    end
  end

  // ========================================================================
  // array, read ahead on the next address so a byte is ready at its fall
  logic [7:0] rdata;

  mfr_array_mem #(.AW(ARRAY_AW)) u_mem (
    .wclk  (mclk),
    .wr    (arr_wr),
    .rclk  (sck),
    .rst_n (rst_n),
    .raddr (addr_d[ARRAY_AW-1:0]),
    .rdata (rdata)
  );

  // ========================================================================
  // output drivers on the falling edge
  logic [3:0] dout_q;
  logic [3:0] dout_d;
  logic [3:0] oe_q;
  logic [3:0] oe_d;

  always_comb begin
    dout_d = 4'h0;
    oe_d   = 4'h0;
    if (ph_q == PH_DATA) begin
      // host must already have released the lines here
      if (cmd_q == CMD_DUAL_IO_FAST_READ) begin
        oe_d = `MFR_MASK_2;
        case (cnt_q[1:0])
          2'h0:    dout_d = {2'h0, rdata[7:6]};
          2'h1:    dout_d = {2'h0, rdata[5:4]};
          2'h2:    dout_d = {2'h0, rdata[3:2]};
          default: dout_d = {2'h0, rdata[1:0]};
        endcase
      end else begin
        oe_d   = `MFR_MASK_4;
        dout_d = cnt_q[0] ? rdata[3:0] : rdata[7:4];
      end
    end
  end

  always_ff @(negedge sck or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      dout_q <= 4'h0;
      oe_q   <= 4'h0;
    end else begin
      dout_q <= dout_d;
      oe_q   <= oe_d;
    end
  end

  assign data_line_out = dout_q;
  assign data_line_oe  = oe_q;

endmodule : mfr_read_front

//--- logic/mfr_consts.svh
`ifndef MFR_CONSTS_SVH
`define MFR_CONSTS_SVH

// ==========================================================================
// command codes
`define MFR_OPC_DUAL_IO_FAST_READ      8'hBB
`define MFR_OPC_QUAD_IO_FAST_READ      8'hEB
`define MFR_OPC_QOR_DFLT  8'h6C
`define MFR_OPC_LAST      5'h07

// ==========================================================================
// frame layout
`define MFR_ADDR_W        24
`define MFR_ADDR_BITS     5'h18
`define MFR_BYTE_BITS     5'h08
`define MFR_QOR_DUMMY     5'h08
`define MFR_QUAD_IO_FAST_READ_DUMMY    5'h04
`define MFR_DUAL_BYTE_LAST 5'h03
`define MFR_QUAD_BYTE_LAST 5'h01
`define MFR_XIP_NIBBLE    4'hA
`define MFR_CFG_QE_BIT    1
`define MFR_ARRAY_AW_DFLT 12

// ==========================================================================
// lane widths, log2 of lines per clock, and the matching output-enable masks
`define MFR_LW_1          2'h0
`define MFR_LW_2          2'h1
`define MFR_LW_4          2'h2
`define MFR_MASK_2        4'h3
`define MFR_MASK_4        4'hF

`endif

//--- logic/mfr_pkg.sv
package mfr_pkg;

  // ========================================================================
  // frame phases
  typedef enum logic [6:0] {
    PH_START  = 7'b0000001,
    PH_OPC    = 7'b0000010,
    PH_ADDR   = 7'b0000100,
    PH_MODE   = 7'b0001000,
    PH_DUMMY  = 7'b0010000,
    PH_DATA   = 7'b0100000,
    PH_IGNORE = 7'b1000000
  } mfr_phase_e;

  // ========================================================================
  // read kinds
  typedef enum logic [3:0] {
    CMD_NONE = 4'b0001,
    CMD_QOR  = 4'b0010,
    CMD_DUAL_IO_FAST_READ = 4'b0100,
    CMD_QUAD_IO_FAST_READ = 4'b1000
  } mfr_cmd_e;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic        en;
    logic [23:0] addr;
    logic [7:0]  data;
  } mfr_wr_s;

  typedef struct packed {
    logic xip_dual;
    logic xip_quad;
  } mfr_stat_s;

endpackage : mfr_pkg

//--- logic/mfr_sync.sv
`timescale 1ns/10ps
module mfr_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // level in and out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // ========================================================================
  // parameter check
  generate
    if (W < 1) begin : g_bad_w
      $error("mfr_sync: W must be at least one");
    end
  endgenerate

  // ========================================================================
  // two flops per bit; the first is read by the second only
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        meta_d[i] = din[i];
        sync_d[i] = meta_q[i];
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= meta_d[i];
          sync_q[i] <= sync_d[i];
        end
      end
    end
  endgenerate

  assign dout = sync_q;

endmodule : mfr_sync

//--- logic/mfr_array_mem.sv
`timescale 1ns/10ps
`include "mfr_consts.svh"
module mfr_array_mem
  import mfr_pkg::*;
#(
  parameter int AW = 12
) (
  // write side, system clock
  input  wire logic          wclk,
  input  mfr_wr_s            wr,
  // read side, link clock
  input  wire logic          rclk,
  input  wire logic          rst_n,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);

  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // ========================================================================
  // parameter check
  generate
    if (AW < 1 || AW > `MFR_ADDR_W) begin : g_bad_aw
      $error("mfr_array_mem: AW out of range");
    end
  endgenerate

  // ========================================================================
  // load port
  always_ff @(posedge wclk) begin
    if (wr.en) begin
      mem[wr.addr[AW-1:0]] <= wr.data;
    end
  end

  // ========================================================================
  // registered read, one word per rising link edge
  always_comb begin
    rdata_d = mem[raddr];
  end

  always_ff @(posedge rclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule : mfr_array_mem

//--- verification/mfr_read_front_chk.sv
`timescale 1ns/10ps
module mfr_read_front_chk
  import mfr_pkg::*;
#(
  parameter int       ARRAY_AW   = 12,
  parameter bit [7:0] QOR_OPCODE = 8'h6C
) (
  // system side
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       busy,
  input  wire logic [7:0] config_reg,
  input  mfr_wr_s         arr_wr,
  input  mfr_stat_s       status,
  // link side
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] data_line_in,
  input  wire logic [3:0] data_line_out,
  input  wire logic [3:0] data_line_oe
);
  // ==========
  // rises seen in the current frame, saturating
  logic [7:0] rise_q;
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) rise_q <= 8'h00;
    else if (rise_q != 8'hFF) rise_q <= rise_q + 8'h01;
  end

  // ==========
  // assertions
  AST_OE_CS_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n |-> data_line_oe == 4'h0) else $error("drive while deselected");
  AST_OE_LANES: assert property (@(posedge mclk) disable iff (!rst_n)
    data_line_oe inside {4'h0, 4'h3, 4'hF}) else $error("bad lane set");
  AST_DRIVE_ON_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
    sck && $past(sck) |-> $stable(data_line_out) && $stable(data_line_oe))
    else $error("data moved while clock high");
  // shortest frame is a continuous quad one: data no earlier than fall 12
  AST_EARLY_QUIET: assert property (@(posedge sck) disable iff (cs_n)
    rise_q < 8'h0C |-> data_line_oe == 4'h0) else $error("drive too early");
  AST_BUSY_REFUSE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(|data_line_oe) |-> !busy && !$past(busy, 4))
    else $error("read served while busy");
  AST_QUAD_NEEDS_QE: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(&data_line_oe) |-> config_reg[1]) else $error("quad without enable");
  AST_STAT_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    !$past(rst_n) |-> status == '0) else $error("flags not cleared");
  AST_STAT_IDLE: assert property (@(posedge mclk) disable iff (!rst_n)
    cs_n && $past(cs_n, 3) |-> $stable(status)) else $error("flag moved idle");
  AST_OE_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !cs_n && !$past(cs_n) && $past(data_line_oe) != 4'h0
    |-> data_line_oe == $past(data_line_oe)) else $error("drive dropped");

  CV_QUAD: cover property (@(posedge mclk) data_line_oe == 4'hF);
  CV_DUAL: cover property (@(posedge mclk) data_line_oe == 4'h3);
  CV_XIPD: cover property (@(posedge mclk) $rose(status.xip_dual));
  CV_XIPQ: cover property (@(posedge mclk) $rose(status.xip_quad));
endmodule : mfr_read_front_chk

bind mfr_read_front mfr_read_front_chk #(
  .ARRAY_AW(ARRAY_AW), .QOR_OPCODE(QOR_OPCODE)
) u_chk (
  .mclk(mclk), .rst_n(rst_n), .busy(busy), .config_reg(config_reg),
  .arr_wr(arr_wr), .status(status), .sck(sck), .cs_n(cs_n),
  .data_line_in(data_line_in), .data_line_out(data_line_out),
  .data_line_oe(data_line_oe)
);

//--- verification/mfr_host_model.sv
`timescale 1ns/10ps
module mfr_host_model (
  // link pins
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] din,
  input  wire logic [3:0] dout,
  input  wire logic [3:0] oe
);
  logic [3:0] s;
  logic       oe_any;
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    din = 4'h0;
    oe_any = 1'b0;
    // deselect after time zero so every frame reset sees a real edge
    #5 cs_n = 1'b1;
  end

  // ==========
  // one clock; lines inverted in the high half so a stale value hides nothing
  task automatic tick(input logic [3:0] v, input bit d);
    din = d ? v : ~din;
    #80 sck = 1'b1;
    s = dout;
    oe_any = oe_any | (|oe);
    #40 din = ~din;
    #40 sck = 1'b0;
  endtask : tick

  task automatic send(input logic [23:0] v, input int n, input int w);
    logic [3:0] x;
    for (int k = 0; k < n / w; k++) begin
      x = 4'h0;
      for (int j = 0; j < w; j++) x[w-1-j] = v[n-1-k*w-j];
      tick(x, 1'b1);
    end
  endtask : send

  task automatic frame(input bit op, input logic [7:0] opc, input int aw,
    input logic [23:0] a, input bit hm, input logic [7:0] m, input int nd,
    input int dw, input int nb, output logic [7:0] q[$]);
    logic [7:0] b;
    q = {};
    oe_any = 1'b0;
    #13 cs_n = 1'b0;
    if (op) send(24'(opc), 8, 1);
    send(a, 24, aw);
    if (hm) send(24'(m), 8, aw);
    repeat (nd) tick(4'h0, 1'b0);
    repeat (nb) begin
      b = 8'h00;
      repeat (8 / dw) begin
        tick(4'h0, 1'b0);
        b = (b << dw) | 8'(s & ((4'h1 << dw) - 4'h1));
      end
      q.push_back(b);
    end
    #40 cs_n = 1'b1;
    #200;
  endtask : frame

  task automatic short_frame(input int n);
    #13 cs_n = 1'b0;
    repeat (n) tick(4'hF, 1'b1);
    #40 cs_n = 1'b1;
    #200;
  endtask : short_frame
endmodule : mfr_host_model

//--- verification/testbench.sv
`timescale 1ns/10ps
`include "mfr_consts.svh"
module testbench
  import mfr_pkg::*;
;
  localparam logic [7:0] QOPC = 8'h3D; // arbitrary code for the bench
  localparam logic [7:0] DOPC = `MFR_OPC_DUAL_IO_FAST_READ;
  localparam logic [7:0] EOPC = `MFR_OPC_QUAD_IO_FAST_READ;
  logic       mclk, rst_n, busy, sck, cs_n;
  logic [7:0] config_reg;
  logic [3:0] din, dout, oe;
  mfr_wr_s    arr_wr;
  mfr_stat_s  status;
  int         n_mismatch, n_compared;
  logic [7:0] q[$];

  mfr_read_front #(.QOR_OPCODE(QOPC)) dut (.mclk(mclk), .rst_n(rst_n),
    .busy(busy), .config_reg(config_reg), .arr_wr(arr_wr),
    .status(status), .sck(sck), .cs_n(cs_n), .data_line_in(din),
    .data_line_out(dout), .data_line_oe(oe));
  mfr_host_model host (.sck(sck), .cs_n(cs_n), .din(din), .dout(dout),
    .oe(oe));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ==========
  // helpers
  function automatic logic [7:0] ex(input logic [23:0] a);
    return a[7:0] ^ {a[11:8], ~a[11:8]};
  endfunction : ex

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  task automatic chk_rd(input logic [23:0] a);
    foreach (q[i]) cmp(q[i], ex(a + 24'(i)));
  endtask : chk_rd

  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask : settle

  task automatic report_and_stop();
    $display("mismatches=%0d compared=%0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ==========
  // scenarios
  task automatic t_quad_out();
    host.frame(1'b1, QOPC, 1, 24'h000123, 1'b0, 8'h00, 8, 4, 3, q);
    chk_rd(24'h000123);
  endtask : t_quad_out

  task automatic t_wrap();
    host.frame(1'b1, EOPC, 4, 24'hFFFFFF, 1'b1, 8'h00, 4, 4, 2, q);
    chk_rd(24'hFFFFFF);
  endtask : t_wrap

  task automatic t_dual_cont();
    host.frame(1'b1, DOPC, 2, 24'h000456, 1'b1, 8'hA5, 0, 2, 2, q);
    chk_rd(24'h000456);
    settle();
    cmp(8'(status.xip_dual), 8'h01);
    host.frame(1'b0, 8'h00, 2, 24'h000A0C, 1'b1, 8'h5A, 0, 2, 2, q);
    chk_rd(24'h000A0C);
    settle();
    cmp(8'(status.xip_dual), 8'h00);
    host.frame(1'b1, DOPC, 2, 24'h000777, 1'b1, 8'hA0, 0, 2, 1, q);
    chk_rd(24'h000777);
    host.short_frame(2);
    host.frame(1'b1, DOPC, 2, 24'h000888, 1'b1, 8'h00, 0, 2, 1, q);
    chk_rd(24'h000888);
  endtask : t_dual_cont

  task automatic t_quad_cont();
    host.frame(1'b1, EOPC, 4, 24'h000321, 1'b1, 8'hAF, 4, 4, 1, q);
    chk_rd(24'h000321);
    host.frame(1'b0, 8'h00, 4, 24'h000654, 1'b1, 8'hA0, 4, 4, 2, q);
    chk_rd(24'h000654);
    settle();
    cmp(8'(status.xip_quad), 8'h01);
    host.short_frame(2);
    host.frame(1'b1, EOPC, 4, 24'h000987, 1'b1, 8'h00, 4, 4, 1, q);
    chk_rd(24'h000987);
    settle();
    cmp(8'(status.xip_quad), 8'h00);
  endtask : t_quad_cont

  task automatic t_refuse();
    @(posedge mclk);
    #2 busy = 1'b1;
    settle();
    host.frame(1'b1, QOPC, 1, 24'h000010, 1'b0, 8'h00, 8, 4, 1, q);
    cmp(8'(host.oe_any), 8'h00);
    @(posedge mclk);
    #2 busy = 1'b0;
    config_reg = 8'h00;
    settle();
    host.frame(1'b1, EOPC, 4, 24'h000020, 1'b1, 8'h00, 4, 4, 1, q);
    cmp(8'(host.oe_any), 8'h00);
    host.frame(1'b1, DOPC, 2, 24'h000030, 1'b1, 8'h00, 0, 2, 1, q);
    chk_rd(24'h000030);
    @(posedge mclk);
    #2 config_reg = 8'h02;
    settle();
    host.frame(1'b1, QOPC, 1, 24'h000040, 1'b0, 8'h00, 8, 4, 1, q);
    chk_rd(24'h000040);
  endtask : t_refuse

  // ==========
  // main sequence and watchdog
  initial begin
    busy = 1'b0;
    config_reg = 8'h02;
    arr_wr = '0;
    rst_n = 1'b1;
    // a falling edge after time zero, not a race with the flops
    #1 rst_n = 1'b0;
    repeat (16) @(posedge mclk);
    #2 rst_n = 1'b1;
    cmp(8'(status), 8'h00);
    for (int i = 0; i < (1 << `MFR_ARRAY_AW_DFLT); i++) begin
      @(posedge mclk);
      #2 arr_wr = '{en: 1'b1, addr: 24'(i), data: ex(24'(i))};
    end
    @(posedge mclk);
    #2 arr_wr.en = 1'b0;
    t_quad_out();
    t_wrap();
    t_dual_cont();
    t_quad_cont();
    t_refuse();
    report_and_stop();
  end

  initial begin
    #1_000_000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : testbench
